/* File: dv/host_model.sv */
// master processor side: secondary memory interface accesses
module host_model (
	// clock
	input  wire logic                   clk_in,
	// one access toward the loader
	output cfg_loader_pkg::mem_access_s bus_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus at time zero
	initial bus_out = '0;

	// single access, held across the taking edge, then released
	task automatic access(input logic wr, input logic [31:0] a, input logic [15:0] d);
		bus_out = '{1'b1, wr, a, d};
		@(posedge clk_in);
		// released lines show the inverse, never a stale copy
		#2 bus_out = '{1'b0, ~wr, ~a, ~d};
	endtask

	// bit writes, msb first, an idle cycle after each so the bit never moves
	// at the edge the previous write raises; bit1 is the inverse of bit0
	// so a loader taking the wrong bit is caught
	task automatic stream(input logic [7:0] bits);
		for (int i = 7; i >= 0; i--) begin
			bus_out = '{1'b1, 1'b1, cfg_loader_pkg::DATA_BASE, {14'h0, ~bits[i], bits[i]}};
			@(posedge clk_in);
			#2 bus_out = '{1'b0, 1'b0, ~cfg_loader_pkg::DATA_BASE, {14'h3FFF, bits[i], ~bits[i]}};
			@(posedge clk_in);
			#2;
		end
	endtask
endmodule

/* File: dv/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
	// stimulus
	logic                        clk, rst, done, pri_stb, ser_q, en;
	logic [15:0]                 gpio;
	logic [1:0]                  mode, st;
	logic [31:0]                 pri_addr, a;
	logic [5:0]                  valid, rdy, gnt;
	cfg_loader_pkg::mem_access_s bus;
	// observed outputs
	logic                        clr, bclk, sbit, fsel, conf, lsel, div6;
	logic [21:0]                 faddr;
	logic [7:0]                  boot, shreg;
	int                          bad_count, check_count, pulses;

	host_model host_u (.clk_in(clk), .bus_out(bus));
	cfg_loader dut_u (.CLK_SYS_IN(clk), .RESET_IN(rst), .CLK_EN_IN(en), .MEM_STROBE_IN(bus.strobe),
		.MEM_WRITE_IN(bus.write), .MEM_ADDR_IN(bus.addr), .MEM_DATA_IN(bus.data), .GPIO_IN(gpio),
		.CLK_MODE_IN(mode), .PRI_STROBE_IN(pri_stb), .PRI_ADDR_IN(pri_addr), .CONFIG_DONE_IN(done),
		.LINK_VALID_IN(valid), .CONFIG_CLEAR_OUT(clr), .CONFIG_BIT_CLOCK_OUT(bclk),
		.SERIAL_CONFIG_BIT_OUT(sbit), .FLASH_SEL_OUT(fsel), .FLASH_ADDR_OUT(faddr), .BOOT_BYTE_OUT(boot),
		.CONFIGURED_OUT(conf), .LOGIC_SEL_OUT(lsel), .LINK_READY_OUT(rdy), .LINK_GRANT_OUT(gnt),
		.CLK_DIV6_OUT(div6), .LOAD_STATE_OUT(st));

	// 40 MHz clock
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end

	// logic side: shift in the bit standing before each bit clock pulse
	always @(posedge clk) begin
		ser_q <= sbit;
		if (bclk === 1'b1) begin
			shreg <= {shreg[6:0], ser_q};
			pulses++;
		end
	end

	// counts, verdict, end of run
	task complete_run;
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// n edges, then settle off the edge
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	// hang guard
	initial begin
		repeat (3000) @(posedge clk);
		bad_count++;
		complete_run;
	end

	initial begin
		{rst, done, pri_stb, pri_addr, valid, mode, gpio} = {3'b100, 32'h0, 6'h0, 2'b10, 16'hA1A5};
		{pulses, shreg, ser_q} = '0;
		en = 1'b1;
		cyc(4);
		rst = 0;
		`CHK({clr, bclk, sbit, fsel, faddr, st, conf, rdy, gnt}, 41'h0)
		// unconfigured: links refuse, logic window closed
		{valid, pri_stb, pri_addr} = {6'b10_1100, 1'b1, cfg_loader_pkg::LOGIC_LAST};
		cyc(2);
		`CHK({rdy, gnt, lsel}, 13'h0)
		`CHK(div6, 1'b1)
		pri_stb = 0;
		// clear first, then the bit stream
		host_u.access(1'b0, cfg_loader_pkg::CLEAR_BASE + 32'h0000_0004, 16'h0000);
		`CHK(clr, 1'b1)
		cyc(1);
		`CHK({clr, st}, 3'b001)
		host_u.stream(8'hB4);
		cyc(2);
		`CHK(pulses, 8)
		`CHK(shreg, 8'hB4)
		`CHK(st, 2'b11)
		// neighbour host space write: no clear, no flash, no bit edge
		host_u.access(1'b1, 32'h6000_0010, 16'h0001);
		`CHK({clr, fsel}, 2'b00)
		cyc(1);
		`CHK({bclk, st}, 3'b011)
		// every flash page, upper boundary on the last; other gpio bits untouched
		for (int p = 0; p < 4; p++) begin
			gpio[10:9] = p[1:0];
			a = cfg_loader_pkg::FLASH_BASE + (p == 3 ? 32'h001F_FFFF : p * 32'h0004_0102);
			host_u.access(1'b0, a, {8'hC3, 6'h0, p[1:0]});
			`CHK({fsel, faddr}, {1'b1, p[1:0], a[19:0]})
			`CHK(boot, {6'h0, p[1:0]})
			cyc(1);
		end
		host_u.access(1'b0, 32'h6420_0000, 16'h0000);
		`CHK(fsel, 1'b0)
		// configuration done crosses in three edges
		done = 1;
		cyc(2);
		`CHK(conf, 1'b0)
		cyc(1);
		`CHK(conf, 1'b1)
		cyc(2);
		`CHK({rdy, gnt}, {6'h3F, 6'b00_0100})
		valid = 6'b00_0001;
		cyc(2);
		`CHK(gnt, 6'b00_0100)
		{pri_stb, pri_addr} = {1'b1, cfg_loader_pkg::LOGIC_LAST};
		cyc(1);
		`CHK(lsel, 1'b1)
		pri_addr = 32'hB010_0000;
		cyc(1);
		`CHK(lsel, 1'b0)
		// frozen clock enable: a clear access is not taken
		en = 1'b0;
		host_u.access(1'b0, cfg_loader_pkg::CLEAR_BASE, 16'h0000);
		`CHK({clr, st}, 3'b010)
		en = 1'b1;
		{pri_stb, mode} = {1'b0, 2'b01};
		cyc(1);
		`CHK(div6, 1'b0)
		complete_run;
	end
endmodule

/* File: hw/cfg_loader.sv */
// Functional notes
// RULE1: clear-space access pulses logic clear line
// RULE2: data-space write shifts bit0, one clock edge
// RULE3: host clears first, then streams bits
// RULE4: flash window paged by two select bits
// RULE5: page bits extend twenty address lines
// RULE6: host changes only page bits
// RULE7: flash sixteen bits, boot uses low byte
// RULE8: boot copies flash start to address zero
// RULE9: configuration forwarded along host port chain
// RULE10: loader locks onto first active link port
// RULE11: link ports not ready until configured
// RULE12: senders wait about one second
// RULE13: logic runs at memory interface rate
// RULE14: mode 10 gives memory clock divide six
// RULE15: primary interface window selects logic
// RULE16: host streams image after clearing
// RULE17: host polls configured status
// RULE18: clear and bit clock last one access
// RULE19: outputs inactive after reset
module cfg_loader #(
	parameter int NUM_LINKS = 6
) (
	// clock, reset, enable
	input  wire logic                   CLK_SYS_IN,
	input  wire logic                   RESET_IN,
	input  wire logic                   CLK_EN_IN,
	// secondary memory interface access (same clock)
	input  wire logic                   MEM_STROBE_IN,
	input  wire logic                   MEM_WRITE_IN,
	input  wire logic [31:0]            MEM_ADDR_IN,
	input  wire logic [15:0]            MEM_DATA_IN,
	// processor general-purpose bits and clock mode
	input  wire logic [15:0]            GPIO_IN,
	input  wire logic [1:0]             CLK_MODE_IN,
	// primary memory interface address
	input  wire logic                   PRI_STROBE_IN,
	input  wire logic [31:0]            PRI_ADDR_IN,
	// configuration done pin (external)
	input  wire logic                   CONFIG_DONE_IN,
	// link ports data present
	input  wire logic [NUM_LINKS-1:0]   LINK_VALID_IN,
	// configuration pins
	output logic                        CONFIG_CLEAR_OUT,
	output logic                        CONFIG_BIT_CLOCK_OUT,
	output logic                        SERIAL_CONFIG_BIT_OUT,
	// flash
	output logic                        FLASH_SEL_OUT,
	output logic [cfg_loader_pkg::FLASH_ABITS-1:0] FLASH_ADDR_OUT,
	output logic [7:0]                  BOOT_BYTE_OUT,
	// status
	output logic                        CONFIGURED_OUT,
	output logic                        LOGIC_SEL_OUT,
	output logic [NUM_LINKS-1:0]        LINK_READY_OUT,
	output logic [NUM_LINKS-1:0]        LINK_GRANT_OUT,
	output logic                        CLK_DIV6_OUT,
	output logic [1:0]                  LOAD_STATE_OUT
);
	// decode wires
	cfg_loader_pkg::mem_access_s acc;
	wire logic                   hit_clear;
	wire logic                   hit_data;
	wire logic                   hit_flash;
	wire logic                   hit_logic;
	wire logic [1:0]             page;
	logic                        done_s1_q;   // first stage, read only by second
	logic                        done_s2_q;
	logic                        data_phase_q; // bit set up, edge pending
	logic [NUM_LINKS-1:0]        grant_q;
	cfg_loader_pkg::load_state_e state_q;
	cfg_loader_pkg::load_state_e state_d;

	// space decode used for the secondary interface clear and data spaces
	// neighbour host space masks to its own value, so forwarding never clears or loads
	function automatic logic in_space(input logic [31:0] a, input logic [31:0] base); // RULE9
		in_space = (a & cfg_loader_pkg::SPACE_MASK) == base;
	endfunction

	assign acc       = '{MEM_STROBE_IN, MEM_WRITE_IN, MEM_ADDR_IN, MEM_DATA_IN};
	assign hit_clear = acc.strobe && in_space(acc.addr, cfg_loader_pkg::CLEAR_BASE); // RULE1
	assign hit_data  = acc.strobe && acc.write && in_space(acc.addr, cfg_loader_pkg::DATA_BASE); // RULE2
	assign hit_flash = acc.strobe && (acc.addr >= cfg_loader_pkg::FLASH_BASE)
		&& (acc.addr <= cfg_loader_pkg::FLASH_LAST); // RULE4
	// ranges share a top, so the inclusive compare suffices
	assign hit_logic = PRI_STROBE_IN && (PRI_ADDR_IN >= cfg_loader_pkg::LOGIC_BASE)
		&& (PRI_ADDR_IN <= cfg_loader_pkg::LOGIC_LAST); // RULE15
	// page bits come straight from the processor pins
	assign page = {GPIO_IN[cfg_loader_pkg::PAGE_HIGH_BIT], GPIO_IN[cfg_loader_pkg::PAGE_LOW_BIT]}; // RULE5

	// done pin synchroniser
	always_ff @(posedge CLK_SYS_IN) begin
		if (RESET_IN) begin
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
		end else if (CLK_EN_IN) begin
			done_s1_q <= CONFIG_DONE_IN;
			done_s2_q <= done_s1_q;
		end
	end

	// loader sequence: clear, then stream, then done
	always_comb begin
		state_d = state_q;
		case (state_q)
			cfg_loader_pkg::ST_IDLE: begin
				if (hit_clear) begin
					state_d = cfg_loader_pkg::ST_CLEARED;
				end
			end
			cfg_loader_pkg::ST_CLEARED: begin
				if (hit_data) begin
					state_d = cfg_loader_pkg::ST_LOADING;
				end
			end
			cfg_loader_pkg::ST_LOADING: begin
				if (done_s2_q) begin
					state_d = cfg_loader_pkg::ST_DONE;
				end
			end
			cfg_loader_pkg::ST_DONE: begin
				if (hit_clear) begin
					state_d = cfg_loader_pkg::ST_CLEARED;
				end
			end
			default: begin
				state_d = cfg_loader_pkg::ST_IDLE;
			end
		endcase
		// a new clear always restarts the sequence
		if (hit_clear) begin
			state_d = cfg_loader_pkg::ST_CLEARED;
		end
	end

	// configuration pin drive; bit set up one cycle before its edge
	always_ff @(posedge CLK_SYS_IN) begin
		if (RESET_IN) begin
			state_q               <= cfg_loader_pkg::ST_IDLE;
			CONFIG_CLEAR_OUT      <= 1'b0; // RULE19
			CONFIG_BIT_CLOCK_OUT  <= 1'b0;
			SERIAL_CONFIG_BIT_OUT <= 1'b0;
			data_phase_q          <= 1'b0;
		end else if (CLK_EN_IN) begin
			state_q          <= state_d;
			CONFIG_CLEAR_OUT <= hit_clear; // RULE1 RULE18
			data_phase_q     <= hit_data;
			if (hit_data) begin
				SERIAL_CONFIG_BIT_OUT <= acc.data[cfg_loader_pkg::CONFIG_BIT_DATA]; // RULE2 RULE18
			end
			// edge one cycle after the bit settles, bit held meanwhile
			// limitation: a write in the very next cycle moves the bit at this edge,
			// so the host leaves one idle cycle between data writes
			CONFIG_BIT_CLOCK_OUT <= data_phase_q; // RULE2 RULE18
		end
	end

	// flash, status and link outputs
	always_ff @(posedge CLK_SYS_IN) begin
		if (RESET_IN) begin
			FLASH_SEL_OUT  <= 1'b0;
			FLASH_ADDR_OUT <= '0; // RULE19 RULE8
			BOOT_BYTE_OUT  <= 8'h00;
			CONFIGURED_OUT <= 1'b0;
			LOGIC_SEL_OUT  <= 1'b0;
			LINK_READY_OUT <= '0;
			grant_q        <= '0;
			CLK_DIV6_OUT   <= 1'b0;
			LOAD_STATE_OUT <= 2'b00;
		end else if (CLK_EN_IN) begin
			FLASH_SEL_OUT  <= hit_flash;
			FLASH_ADDR_OUT <= {page, acc.addr[cfg_loader_pkg::WINDOW_ABITS-1:0]}; // RULE4 RULE5
			BOOT_BYTE_OUT  <= acc.data[cfg_loader_pkg::BOOT_BYTE_BITS-1:0]; // RULE7
			CONFIGURED_OUT <= done_s2_q; // RULE17
			LOGIC_SEL_OUT  <= hit_logic && done_s2_q; // RULE13 RULE15
			LINK_READY_OUT <= {NUM_LINKS{done_s2_q}}; // RULE11
			CLK_DIV6_OUT   <= CLK_MODE_IN == cfg_loader_pkg::CLK_MODE_DIV6; // RULE14
			LOAD_STATE_OUT <= state_q;
			// lock onto lowest active port; others ignored until reset or until the synchronised done drops
			if (!done_s2_q) begin
				grant_q <= '0;
			end else if (grant_q == '0) begin
				grant_q <= LINK_VALID_IN & (~LINK_VALID_IN + 1'b1); // RULE10
			end
		end
	end
	assign LINK_GRANT_OUT = grant_q;

	// bit clock follows a data-space write by two cycles
	bit_edge_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN) // RULE2
		CLK_EN_IN && hit_data ##1 CLK_EN_IN |=> CONFIG_BIT_CLOCK_OUT)
		else $error("bit clock edge missing");
	// clear lasts one access
	clear_pulse_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN) // RULE18
		CLK_EN_IN && !hit_clear |=> !CONFIG_CLEAR_OUT)
		else $error("clear line too long");
	// a data write sets the serial bit at the next edge
	bit_load_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN) // RULE2
		CLK_EN_IN && hit_data |=> SERIAL_CONFIG_BIT_OUT == $past(acc.data[cfg_loader_pkg::CONFIG_BIT_DATA]))
		else $error("serial bit not loaded");
	// bit standing before the rising edge is the one written two cycles earlier
	bit_stable_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN) // RULE18
		$rose(CONFIG_BIT_CLOCK_OUT) && $past(CLK_EN_IN) && $past(CLK_EN_IN, 2)
		|-> $past(SERIAL_CONFIG_BIT_OUT) == $past(acc.data[cfg_loader_pkg::CONFIG_BIT_DATA], 2))
		else $error("serial bit moved at edge");
	// not ready before configuration
	link_wait_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN) // RULE11
		!done_s2_q |-> ##1 (LINK_READY_OUT == '0 || !CLK_EN_IN))
		else $error("link ready too early");
	// at most one port granted
	one_grant_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN) // RULE10
		$onehot0(grant_q))
		else $error("several ports granted");
	// page bits reach top address lines
	page_addr_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN) // RULE4
		CLK_EN_IN |=> FLASH_ADDR_OUT[cfg_loader_pkg::FLASH_ABITS-1 -: 2] == $past(page))
		else $error("page select not applied");
	// clear restarts the loader
	clear_state_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN) // RULE1
		CLK_EN_IN && hit_clear |=> state_q == cfg_loader_pkg::ST_CLEARED)
		else $error("clear did not restart");
	// logic window gated by configuration
	logic_sel_a: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN) // RULE15
		LOGIC_SEL_OUT |-> $past(done_s2_q))
		else $error("logic selected unconfigured");
endmodule

/* File: hw/cfg_loader_pkg.sv */
package cfg_loader_pkg;
	// secondary memory interface chip-select windows (byte addresses)
	localparam logic [31:0] FLASH_BASE        = 32'h6400_0000;
	localparam logic [31:0] FLASH_LAST        = 32'h641F_FFFF;
	localparam logic [31:0] CLEAR_BASE        = 32'h6800_0000;
	localparam logic [31:0] DATA_BASE         = 32'h6C00_0000;
	localparam logic [31:0] SPACE_MASK        = 32'hFC00_0000;
	// primary memory interface window to the logic
	localparam logic [31:0] LOGIC_BASE        = 32'hB000_0000;
	localparam logic [31:0] LOGIC_LAST        = 32'hB00F_FFFF;
	// flash paging
	localparam int          PAGE_BITS         = 2;
	localparam int          WINDOW_ABITS      = 20;
	localparam int          FLASH_ABITS       = 22;
	localparam int          PAGE_LOW_BIT      = 9;
	localparam int          PAGE_HIGH_BIT     = 10;
	localparam int          BOOT_BYTE_BITS    = 8;
	localparam int          FLASH_DATA_BITS   = 16;
	// clocking
	localparam int          CLK_MHZ           = 40;
	localparam logic [1:0]  CLK_MODE_DIV6     = 2'b10;
	localparam int          MEM_CLK_DIV       = 6;
	localparam int          CONFIG_BIT_DATA   = 0;

	// one decoded memory access
	typedef struct packed {
		logic        strobe;
		logic        write;
		logic [31:0] addr;
		logic [15:0] data;
	} mem_access_s;

	// loader sequence
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_CLEARED = 2'b01,
		ST_LOADING = 2'b11,
		ST_DONE    = 2'b10
	} load_state_e;
endpackage
